// File: verilog/eadl_map.vh
/*
 * Constants of the external area decode and lane steering block:
 * area codes, width codes, memory types and the area 0 wait table.
 * Assumes inclusion by its bare name from the block's design files.
 */
`ifndef EADL_MAP_VH
`define EADL_MAP_VH

// ==========
// Area decode field of the physical address
`define EADL_AREA_HI   28
`define EADL_AREA_LO   26
`define EADL_AREA0     3'h0
`define EADL_AREA1     3'h1
`define EADL_AREA2     3'h2

// ==========
// Bus width codes (00 is reserved and treated as longword)
`define EADL_W_RSVD    2'h0
`define EADL_W_BYTE    2'h1
`define EADL_W_WORD    2'h2
`define EADL_W_LONG    2'h3

// ==========
// Area 2 memory types
`define EADL_MEM_NORMAL 2'h0
`define EADL_MEM_DRAM   2'h1
`define EADL_MEM_SDRAM  2'h2

// ==========
// Area 0 wait code to wait cycles
`define EADL_WAIT_C0   4'h0
`define EADL_WAIT_C1   4'h1
`define EADL_WAIT_C2   4'h2
`define EADL_WAIT_C3   4'h3
`define EADL_WAIT_C4   4'h4
`define EADL_WAIT_C5   4'h6
`define EADL_WAIT_C6   4'h8
`define EADL_WAIT_C7   4'ha

// ==========
// Burst pitch floor in cycles
`define EADL_BURST_MIN 4'h2

`endif

// File: verilog/eadl_sync2.v
/*
 * Two flip-flop synchroniser for a group of pin inputs.
 * Assumes each bit is independent; multi-bit words must be stable
 * around the sampling edge.
 */
`timescale 1ns/10ps

module eadl_sync2 #(
   parameter W = 1
) (
   // Clock
   input  wire         clk,
   // Asynchronous inputs
   input  wire [W-1:0] pinIn,
   // Synchronised outputs
   output wire [W-1:0] safeOut
);

   reg [W-1:0] stage1_reg;
   reg [W-1:0] stage2_reg;

   // ==========
   // First stage is read only by the second
   always @(posedge clk) begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
   end

   assign safeOut = stage2_reg;

endmodule

// File: verilog/eadl_lane.v
/*
 * Little-endian lane steering for one bus beat.
 * Assumes the beat address is aligned to the beat size and the data
 * is the beat's chunk, right aligned.
 */
`timescale 1ns/10ps

module eadl_lane (
   // Beat description
   input  wire [1:0]  devLog,
   input  wire [1:0]  beatLog,
   input  wire [1:0]  beatAddr,
   input  wire [31:0] chunk,
   // Steering results
   output reg  [3:0]  laneMask,
   output reg  [1:0]  laneOff,
   output wire [31:0] laneData
);

   // ==========
   // First lane of the beat
   always @* begin
      laneOff = 2'h0;
      if (devLog == 2'h2) begin
         if (beatLog == 2'h0) begin
            laneOff = beatAddr;
         end else if (beatLog == 2'h1) begin
            laneOff = {beatAddr[1], 1'b0};
         end
      end else if (devLog == 2'h1 && beatLog == 2'h0) begin
         laneOff = {1'b0, beatAddr[0]};
      end
   end

   // Lanes covered by the beat
   always @* begin
      case (beatLog)
         2'h0: laneMask = 4'h1 << laneOff;
         2'h1: laneMask = 4'h3 << laneOff;
         default: laneMask = 4'hf;
      endcase
   end

   // Data moved onto its lanes
   assign laneData = chunk << {laneOff, 3'h0};

endmodule

// File: verilog/eadl_top.v
/*
 * External bus front end for areas 0, 1 and 2: area decode, chip
 * selects, wait insertion, burst pitch and little-endian lane steering.
 * Assumes a CPU request port on clk and asynchronous memory pins.
 */
// Overview of operation
// - Address bits 28..26 = 000 select area 0, its select held all access.
// - Address bits 28..26 = 001 select area 1 and assert its select.
// - Address bits 28..26 = 010 select area 2 and assert its select.
// - Address bits 31..29 ignored, so each area repeats every 512 MB.
// - Area 0 width comes from two boot pins caught once after reset.
// - Area 0 inserts 0 to 10 waits from its 3-bit wait code.
// - Areas 0 to 2 stretch each cycle while the wait pin is low.
// - Area 0 burst ROM beats have a pitch of 2 to 10 cycles.
// - Normal memory gets a read strobe and four per-lane write strobes.
// - Area 1 is normal memory, width from its two-bit size field.
// - Areas 1 and 2 share one two-bit wait field, 0 to 3 waits.
// - Area 2 normal memory width from its two-bit size field.
// - Area 2 synchronous DRAM width follows the DRAM size bit.
// - Area 2 DRAM is fixed at 16 bits; area 3 must match.
// - 16-bit devices: even bytes lane 0, odd lane 1, longword two beats.
// - 8-bit devices: lane 0 only, words two beats, longwords four.
`timescale 1ns/10ps
`include "eadl_map.vh"

module eadl_top (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // CPU request
   input  wire        reqValid,
   input  wire [31:0] reqAddr,
   input  wire        reqWrite,
   input  wire [1:0]  reqSize,
   input  wire [31:0] reqWdata,
   output wire        reqReady,
   // CPU response
   output wire        rspValid,
   output wire        rspError,
   output wire [31:0] rspRdata,
   // Configuration bits
   input  wire [2:0]  area0_wait_count,
   input  wire [1:0]  area12_wait_count,
   input  wire [1:0]  area1_width_sel,
   input  wire [1:0]  area2_width_sel,
   input  wire [1:0]  area2MemType,
   input  wire        dram_width_bit,
   input  wire        area0BurstEnable,
   // Boot and wait pins
   input  wire        boot_width_pin_a,
   input  wire        boot_width_pin_b,
   input  wire        waitN,
   // Memory bus
   output wire [25:0] extAddr,
   output wire        area0_select_n,
   output wire        area1_select_n,
   output wire        area2_select_n,
   output wire        readStrobeN,
   output wire        write_strobe_lane0_n,
   output wire        write_strobe_lane1_n,
   output wire        write_strobe_lane2_n,
   output wire        write_strobe_lane3_n,
   output wire [31:0] dataOut,
   output wire [3:0]  dataOutEnN,
   input  wire [31:0] dataIn
);

   // ==========
   // States
   localparam S_IDLE   = 3'h0;
   localparam S_LOAD   = 3'h1;
   localparam S_ACCESS = 3'h2;
   localparam S_GAP    = 3'h3;
   localparam S_TAIL   = 3'h4;

   reg  [2:0]  state_reg;
   reg         bootDone_reg;
   reg  [1:0]  area0Width_reg;
   reg         reqReady_reg;
   reg         rspValid_reg;
   reg         rspError_reg;
   reg  [31:0] rspRdata_reg;
   reg  [2:0]  selectN_reg;
   reg         readStrobeN_reg;
   reg  [3:0]  writeStrobeN_reg;
   reg  [31:0] dataOut_reg;
   reg  [3:0]  dataOutEnN_reg;
   reg  [25:0] extAddr_reg;
   reg  [25:0] addr_reg;
   reg         write_reg;
   reg  [31:0] wdata_reg;
   reg  [1:0]  devLog_reg;
   reg  [1:0]  beatLog_reg;
   reg  [1:0]  beat_reg;
   reg  [1:0]  beatLast_reg;
   reg  [3:0]  waits_reg;
   reg  [3:0]  burstCnt_reg;
   reg         burst_reg;
   reg  [3:0]  cnt_reg;
   reg  [31:0] rdAcc_reg;
   reg         capA_reg;
   reg         capB_reg;
   reg  [6:0]  capShiftA_reg;
   reg  [6:0]  capShiftB_reg;
   reg  [1:0]  capOffA_reg;
   reg  [1:0]  capOffB_reg;

   wire [2:0]  ctlSafe;
   wire [31:0] dataSafe;
   wire [3:0]  laneMask;
   wire [1:0]  laneOff;
   wire [31:0] laneData;

   // ==========
   // Pin synchronisers
   eadl_sync2 #(.W(3)) ctlSync (
      .clk     (clk),
      .pinIn   ({boot_width_pin_b, boot_width_pin_a, waitN}),
      .safeOut (ctlSafe)
   );

   eadl_sync2 #(.W(32)) dataSync (
      .clk     (clk),
      .pinIn   (dataIn),
      .safeOut (dataSafe)
   );

   wire waitActive = ~ctlSafe[0];

   // ==========
   // Helper functions
   function [1:0] widthLog;
      input [1:0] code;
      begin
         case (code)
            `EADL_W_BYTE: widthLog = 2'h0;
            `EADL_W_WORD: widthLog = 2'h1;
            default:      widthLog = 2'h2;          // Reserved code acts as longword
         endcase
      end
   endfunction

   function [3:0] area0Waits;
      input [2:0] code;
      begin
         case (code)
            3'h0: area0Waits = `EADL_WAIT_C0;
            3'h1: area0Waits = `EADL_WAIT_C1;
            3'h2: area0Waits = `EADL_WAIT_C2;
            3'h3: area0Waits = `EADL_WAIT_C3;
            3'h4: area0Waits = `EADL_WAIT_C4;
            3'h5: area0Waits = `EADL_WAIT_C5;
            3'h6: area0Waits = `EADL_WAIT_C6;
            default: area0Waits = `EADL_WAIT_C7;
         endcase
      end
   endfunction

   // ==========
   // Area decode, upper three address bits never looked at
   wire [2:0] reqArea = reqAddr[`EADL_AREA_HI:`EADL_AREA_LO];
   wire       areaOk  = (reqArea == `EADL_AREA0) || (reqArea == `EADL_AREA1) ||
                        (reqArea == `EADL_AREA2);

   // Device width of the addressed area
   reg [1:0] devCode;
   always @* begin
      case (reqArea)
         `EADL_AREA0: devCode = area0Width_reg;
         `EADL_AREA1: devCode = area1_width_sel;
         default: begin
            case (area2MemType)
               `EADL_MEM_DRAM:  devCode = `EADL_W_WORD;
               `EADL_MEM_SDRAM: devCode = dram_width_bit ? `EADL_W_LONG :
                                          `EADL_W_WORD;
               default:         devCode = area2_width_sel;
            endcase
         end
      endcase
   end

   // Waits of the addressed area
   wire [3:0] reqWaits = (reqArea == `EADL_AREA0) ? area0Waits(area0_wait_count) :
                         {2'h0, area12_wait_count};

   // Beat split: a wide access on a narrow device becomes several beats
   wire [1:0] devLogReq  = widthLog(devCode);
   wire [1:0] accLogReq  = widthLog(reqSize);
   wire [1:0] beatLogReq = (accLogReq > devLogReq) ? devLogReq : accLogReq;
   wire [1:0] beatsLog   = accLogReq - beatLogReq;
   wire [1:0] lastReq    = (beatsLog == 2'h2) ? 2'h3 : {1'b0, beatsLog[0]};

   // Burst pitch count, beats after the first run LOAD plus ACCESS
   wire [3:0] pitchReq   = (reqWaits < `EADL_BURST_MIN) ? `EADL_BURST_MIN : reqWaits;
   wire [3:0] burstCnt   = pitchReq - `EADL_BURST_MIN;

   // ==========
   // Current beat: ascending address, low part of the data first
   wire [25:0] beatStep = {24'h000000, beat_reg} << devLog_reg;
   wire [25:0] beatAddr = addr_reg + beatStep;
   wire [2:0]  shiftExp = {1'b0, devLog_reg} + 3'h3;
   wire [6:0]  bitShift = {5'h00, beat_reg} << shiftExp;
   wire [31:0] chunk    = wdata_reg >> bitShift;

   eadl_lane lane (
      .devLog   (devLog_reg),
      .beatLog  (beatLog_reg),
      .beatAddr (beatAddr[1:0]),
      .chunk    (chunk),
      .laneMask (laneMask),
      .laneOff  (laneOff),
      .laneData (laneData)
   );

   // Read data picked from its lanes and trimmed to the beat size
   wire [31:0] beatKeep  = (beatLog_reg == 2'h0) ? 32'h000000ff :
                           (beatLog_reg == 2'h1) ? 32'h0000ffff : 32'hffffffff;
   wire [31:0] readChunk = (dataSafe >> {capOffB_reg, 3'h0}) & beatKeep;
   wire [31:0] readPlace = readChunk << capShiftB_reg;

   wire take    = reqValid && reqReady_reg;
   wire beatEnd = (state_reg == S_ACCESS) && (cnt_reg == 4'h0) && !waitActive;

   // ==========
   // Area 0 width caught from the boot pins once after reset
   always @(posedge clk) begin
      if (reset) begin
         bootDone_reg   <= 1'b0;
         area0Width_reg <= `EADL_W_LONG;
      end else if (!bootDone_reg) begin
         bootDone_reg   <= 1'b1;
         area0Width_reg <= ctlSafe[2:1];
      end
   end

   // ==========
   // Access sequencer
   always @(posedge clk) begin
      if (reset) begin
         state_reg        <= S_IDLE;
         reqReady_reg     <= 1'b0;
         rspValid_reg     <= 1'b0;
         rspError_reg     <= 1'b0;
         rspRdata_reg     <= 32'h00000000;
         selectN_reg      <= 3'h7;
         readStrobeN_reg  <= 1'b1;
         writeStrobeN_reg <= 4'hf;
         dataOut_reg      <= 32'h00000000;
         dataOutEnN_reg   <= 4'hf;
         extAddr_reg      <= 26'h0000000;
         addr_reg         <= 26'h0000000;
         write_reg        <= 1'b0;
         wdata_reg        <= 32'h00000000;
         devLog_reg       <= 2'h0;
         beatLog_reg      <= 2'h0;
         beat_reg         <= 2'h0;
         beatLast_reg     <= 2'h0;
         waits_reg        <= 4'h0;
         burstCnt_reg     <= 4'h0;
         burst_reg        <= 1'b0;
         cnt_reg          <= 4'h0;
         rdAcc_reg        <= 32'h00000000;
         capA_reg         <= 1'b0;
         capB_reg         <= 1'b0;
         capShiftA_reg    <= 7'h00;
         capShiftB_reg    <= 7'h00;
         capOffA_reg      <= 2'h0;
         capOffB_reg      <= 2'h0;
      end else begin
         rspValid_reg  <= 1'b0;
         rspError_reg  <= 1'b0;
         // Read capture waits out the two synchroniser stages
         capA_reg      <= beatEnd && !write_reg;
         capShiftA_reg <= bitShift;
         capOffA_reg   <= laneOff;
         capB_reg      <= capA_reg;
         capShiftB_reg <= capShiftA_reg;
         capOffB_reg   <= capOffA_reg;
         if (capB_reg) begin
            rdAcc_reg <= rdAcc_reg | readPlace;
         end
         case (state_reg)
            S_IDLE: begin
               reqReady_reg <= bootDone_reg;
               if (take) begin
                  reqReady_reg <= 1'b0;
                  if (!areaOk) begin
                     rspValid_reg <= 1'b1;                         // Areas 3 to 7 refused
                     rspError_reg <= 1'b1;
                  end else begin
                     addr_reg     <= reqAddr[25:0];
                     write_reg    <= reqWrite;
                     wdata_reg    <= reqWdata;
                     devLog_reg   <= devLogReq;
                     beatLog_reg  <= beatLogReq;
                     beatLast_reg <= lastReq;
                     beat_reg     <= 2'h0;
                     waits_reg    <= reqWaits;
                     burstCnt_reg <= burstCnt;
                     burst_reg    <= (reqArea == `EADL_AREA0) && area0BurstEnable && !reqWrite;
                     rdAcc_reg    <= 32'h00000000;
                     selectN_reg  <= ~(3'h1 << reqArea[1:0]);
                     state_reg    <= S_LOAD;
                  end
               end
            end
            S_LOAD: begin
               extAddr_reg <= beatAddr;
               if (write_reg) begin
                  writeStrobeN_reg <= ~laneMask;
                  dataOut_reg      <= laneData;
                  dataOutEnN_reg   <= ~laneMask;
               end else begin
                  readStrobeN_reg  <= 1'b0;
               end
               if (burst_reg && beat_reg != 2'h0) begin
                  cnt_reg <= burstCnt_reg;
               end else begin
                  cnt_reg <= waits_reg;
               end
               state_reg <= S_ACCESS;
            end
            S_ACCESS: begin
               if (cnt_reg != 4'h0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end else if (!waitActive) begin
                  writeStrobeN_reg <= 4'hf;
                  dataOutEnN_reg   <= 4'hf;
                  if (beat_reg == beatLast_reg) begin
                     selectN_reg     <= 3'h7;
                     readStrobeN_reg <= 1'b1;
                     if (write_reg) begin
                        rspValid_reg <= 1'b1;
                        reqReady_reg <= 1'b1;
                        state_reg    <= S_IDLE;
                     end else begin
                        state_reg <= S_TAIL;
                     end
                  end else begin
                     beat_reg <= beat_reg + 2'h1;
                     if (burst_reg) begin
                        state_reg <= S_LOAD;
                     end else begin
                        readStrobeN_reg <= 1'b1;
                        state_reg       <= S_GAP;
                     end
                  end
               end
            end
            S_GAP: begin
               state_reg <= S_LOAD;
            end
            S_TAIL: begin
               if (!capA_reg && !capB_reg) begin
                  rspValid_reg <= 1'b1;
                  rspRdata_reg <= rdAcc_reg;
                  reqReady_reg <= 1'b1;
                  state_reg    <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ==========
   // Outputs straight from flip-flops
   assign reqReady             = reqReady_reg;
   assign rspValid             = rspValid_reg;
   assign rspError             = rspError_reg;
   assign rspRdata             = rspRdata_reg;
   assign extAddr              = extAddr_reg;
   assign area0_select_n       = selectN_reg[0];
   assign area1_select_n       = selectN_reg[1];
   assign area2_select_n       = selectN_reg[2];
   assign readStrobeN          = readStrobeN_reg;
   assign write_strobe_lane0_n = writeStrobeN_reg[0];
   assign write_strobe_lane1_n = writeStrobeN_reg[1];
   assign write_strobe_lane2_n = writeStrobeN_reg[2];
   assign write_strobe_lane3_n = writeStrobeN_reg[3];
   assign dataOut              = dataOut_reg;
   assign dataOutEnN           = dataOutEnN_reg;

endmodule

// File: bench/eadl_top_asserts.sv
/* Port checker of the area front end.
   Assumes it is bound to eadl_top and sees only its ports. */
`timescale 1ns/10ps
module eadl_top_asserts (
   // Clock and reset
   input wire        clk,
   input wire        reset,
   // CPU side
   input wire        reqValid,
   input wire        reqReady,
   input wire [31:0] reqAddr,
   input wire        rspError,
   input wire [1:0]  area1_width_sel,
   // Memory bus
   input wire        area0_select_n,
   input wire        area1_select_n,
   input wire        area2_select_n,
   input wire        readStrobeN,
   input wire        write_strobe_lane0_n,
   input wire        write_strobe_lane1_n,
   input wire        write_strobe_lane2_n,
   input wire        write_strobe_lane3_n,
   input wire [3:0]  dataOutEnN
);
   // ==========
   // Grouped views and assertions
   wire [3:0] wrN = {write_strobe_lane3_n, write_strobe_lane2_n, write_strobe_lane1_n, write_strobe_lane0_n};
   wire [2:0] selN = {area2_select_n, area1_select_n, area0_select_n};
   wire       take = reqValid && reqReady;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_area0_select: assert property (take && reqAddr[28:26] == 3'h0 |-> ##[1:2] selN == 3'h6)
      else $error("area 0 select missing");
   a_area1_select: assert property (take && reqAddr[28:26] == 3'h1 |-> ##[1:2] selN == 3'h5)
      else $error("area 1 select missing");
   a_area2_select: assert property (take && reqAddr[28:26] == 3'h2 |-> ##[1:2] selN == 3'h3)
      else $error("area 2 select missing");
   a_other_area: assert property (take && reqAddr[28:26] > 3'h2 |-> ##[1:2] (rspError && selN == 3'h7))
      else $error("unmapped area not refused");
   a_one_select: assert property ($countones(~selN) <= 1)
      else $error("two selects low");
   a_idle_quiet: assert property (selN == 3'h7 |-> readStrobeN && wrN == 4'hf)
      else $error("strobe outside access");
   a_read_apart: assert property (!readStrobeN |-> wrN == 4'hf)
      else $error("read and write strobes together");
   a_lane_driven: assert property ((~wrN & dataOutEnN) == 4'h0)
      else $error("strobed lane not driven");
   a_busy_ready: assert property (selN != 3'h7 |-> !reqReady)
      else $error("ready during access");
   a_byte_lane: assert property (!area1_select_n && area1_width_sel == 2'h1 |-> wrN[3:1] == 3'h7)
      else $error("upper lane strobed on byte device");
   c_area2: cover property (take && reqAddr[28:26] == 3'h2);
   c_refused: cover property (rspError);
   c_long_read: cover property ((!area0_select_n && !readStrobeN) [*4]);
endmodule
bind eadl_top eadl_top_asserts u_chk (.clk, .reset, .reqValid, .reqReady, .reqAddr, .rspError,
   .area1_width_sel, .area0_select_n, .area1_select_n, .area2_select_n, .readStrobeN,
   .write_strobe_lane0_n, .write_strobe_lane1_n, .write_strobe_lane2_n, .write_strobe_lane3_n, .dataOutEnN);

// File: bench/eadl_mem_model.sv
/* Byte memory on the far side of the bus, with wait insertion.
   Assumes the bench tells it the width of the device addressed. */
`timescale 1ns/10ps
module eadl_mem_model (
   // Clock
   input wire        clk,
   // Test controls
   input wire [2:0]  devBytes,
   input wire [3:0]  waitLen,
   // Memory bus
   input wire [25:0] extAddr,
   input wire [2:0]  selN,
   input wire        readStrobeN,
   input wire [3:0]  wrN,
   input wire [31:0] dataOut,
   output wire [31:0] dataIn,
   output reg        waitN
);
   // ==========
   // Storage and lane mapping
   reg  [7:0]  mem [0:255];
   reg  [31:0] lastD;
   reg  [3:0]  cnt;
   integer     i;
   wire [7:0]  st = devBytes == 3'h1 ? 8'h0 : 8'h1;
   wire [7:0]  a0 = extAddr[7:0] & ~({5'h0, devBytes} - 8'h1);
   wire [31:0] rdD = {mem[a0 + 8'h3 * st], mem[a0 + 8'h2 * st], mem[a0 + st], mem[a0]};
   initial begin
      waitN = 1'b1;
      lastD = 32'h0;
      cnt = 4'h0;
      for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h5a;
   end
   // Released bus shows the inverse of its last value
   assign dataIn = readStrobeN ? ~lastD : rdD;
   // Lane writes land while their strobe is low
   always @(negedge clk) begin
      if (!readStrobeN) lastD <= rdD;
      for (i = 0; i < 4; i = i + 1) if (!wrN[i]) mem[a0 + i[7:0] * st] <= dataOut[8*i +: 8];
   end
   // Hold wait low for waitLen cycles from select
   always @(posedge clk) begin
      cnt <= selN == 3'h7 ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
      waitN <= !(selN != 3'h7 && cnt < waitLen);
   end
endmodule

// File: bench/eadl_top_tb_top.sv
/* Testbench of the area decode and lane steering front end.
   Assumes the memory model and the bound port checker. */
`timescale 1ns/10ps
module eadl_top_tb_top;
   // ==========
   // Signals
   reg         clk, reset, reqValid, reqWrite, dram_width_bit, errOut, anyS, prevS, rdPrev;
   reg         area0BurstEnable, boot_width_pin_a, boot_width_pin_b;
   reg  [31:0] reqAddr, reqWdata, rdOut, a;
   reg  [1:0]  reqSize, area12_wait_count, area1_width_sel, area2_width_sel, area2MemType;
   reg  [2:0]  area0_wait_count, devBytes, selSeen;
   reg  [3:0]  waitLen, laneSeen;
   reg  [25:0] prevA;
   integer     errors, check_count, sCyc, beats, rdFalls, addrCh, tNow, tF, tL, k;
   wire        reqReady, rspValid, rspError, readStrobeN, waitN;
   wire        area0_select_n, area1_select_n, area2_select_n;
   wire        write_strobe_lane0_n, write_strobe_lane1_n, write_strobe_lane2_n, write_strobe_lane3_n;
   wire [31:0] rspRdata, dataOut, dataIn;
   wire [25:0] extAddr;
   wire [3:0]  dataOutEnN;
   wire [3:0]  wrN = {write_strobe_lane3_n, write_strobe_lane2_n, write_strobe_lane1_n, write_strobe_lane0_n};
   wire [2:0]  selN = {area2_select_n, area1_select_n, area0_select_n};
   eadl_top u_dut (.clk, .reset, .reqValid, .reqAddr, .reqWrite, .reqSize, .reqWdata, .reqReady, .rspValid,
      .rspError, .rspRdata, .area0_wait_count, .area12_wait_count, .area1_width_sel, .area2_width_sel,
      .area2MemType, .dram_width_bit, .area0BurstEnable, .boot_width_pin_a, .boot_width_pin_b, .waitN,
      .extAddr, .area0_select_n, .area1_select_n, .area2_select_n, .readStrobeN, .write_strobe_lane0_n,
      .write_strobe_lane1_n, .write_strobe_lane2_n, .write_strobe_lane3_n, .dataOut, .dataOutEnN, .dataIn);
   eadl_mem_model u_mem (.clk, .devBytes, .waitLen, .extAddr, .selN, .readStrobeN, .wrN, .dataOut,
      .dataIn, .waitN);
   // Clock at 50 MHz
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Bus monitor: strobe cycles, beats, burst address steps
   always @(negedge clk) begin
      tNow = tNow + 1;
      anyS = !readStrobeN || wrN != 4'hf;
      if (anyS) sCyc = sCyc + 1;
      if (anyS && !prevS) beats = beats + 1;
      if (!readStrobeN && rdPrev) rdFalls = rdFalls + 1;
      if (!readStrobeN && !rdPrev && extAddr != prevA) begin
         addrCh = addrCh + 1;
         if (addrCh == 1) tF = tNow;
         tL = tNow;
      end
      rdPrev = readStrobeN;
      prevS = anyS;
      prevA = extAddr;
      selSeen = selSeen | ~selN;
      laneSeen = laneSeen | ~wrN;
   end
   // ==========
   // Tasks
   task print_verdict;
      begin
         if (errors == 0 && check_count > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task rst(input [1:0] bw);
      begin
         @(negedge clk);
         {boot_width_pin_b, boot_width_pin_a} = bw;
         reset = 1'b1;
         repeat (10) @(negedge clk);
         reset = 1'b0;
         repeat (3) @(negedge clk);
      end
   endtask
   // One CPU access, held until taken, then waited out
   task acc(input [31:0] ad, input w, input [1:0] s, input [31:0] wd, input [2:0] dv);
      integer n;
      begin
         @(negedge clk);
         devBytes = dv;
         {sCyc, beats, rdFalls, addrCh} = 128'h0;
         {selSeen, laneSeen} = 7'h0;
         {reqValid, reqAddr, reqWrite, reqSize, reqWdata} = {1'b1, ad, w, s, wd};
         n = 0;
         while (reqReady !== 1'b1 && n < 200) begin
            @(negedge clk);
            n = n + 1;
         end
         @(negedge clk);
         reqValid = 1'b0;
         while (rspValid !== 1'b1 && n < 200) begin
            @(negedge clk);
            n = n + 1;
         end
         if (n >= 200) begin
            errors = errors + 1;
            print_verdict;
         end
         rdOut = rspRdata;
         errOut = rspError;
      end
   endtask
   task lay(input [7:0] ad, input [31:0] v, input integer nb);
      integer j;
      for (j = 0; j < nb; j = j + 1) chk(u_mem.mem[ad + j], v[8*j +: 8]);
   endtask
   function [3:0] w0(input [2:0] c);
      w0 = c < 3'h5 ? {1'b0, c} : {c, 1'b0} - 4'h4;
   endfunction
   // ==========
   // Main sequence
   initial begin
      {reset, reqValid, reqWrite, dram_width_bit, area0BurstEnable} = 5'h10;
      {reqAddr, reqWdata, reqSize, area12_wait_count, area0_wait_count, area2MemType} = 73'h0;
      {boot_width_pin_b, boot_width_pin_a, area1_width_sel, area2_width_sel} = 6'h16;
      {devBytes, waitLen, errors, check_count, tNow, prevS, rdPrev, prevA} = {3'h1, 4'h0, 96'h0, 2'h1, 26'h0};
      rst(2'h1);
      for (k = 0; k < 3; k = k + 1) begin
         a = {k[2:0] + 3'h1, k[2:0], 18'h0, 8'h20} + k * 8;
         acc(a, 1'b1, 2'h3, 32'h88776655 + k, k < 2 ? 3'h1 : 3'h2);
         chk(selSeen, 1 << k);
         chk(beats, k < 2 ? 4 : 2);
         lay(a[7:0], 32'h88776655 + k, 4);
         acc(a, 1'b0, 2'h3, 32'h0, k < 2 ? 3'h1 : 3'h2);
         chk(rdOut, 32'h88776655 + k);
      end
      acc(32'h0c000000, 1'b1, 2'h3, 32'h1, 3'h1);
      chk({errOut, selSeen}, 4'h8);
      for (k = 0; k < 3; k = k + 1) begin
         acc(32'h08000030 + k, 1'b1, k == 2 ? 2'h2 : 2'h1, 32'hc0de, 3'h2);
         chk(laneSeen, k + 1);
         lay(8'h30 + k, 32'hc0de, k == 2 ? 2 : 1);
      end
      acc(32'h04000040, 1'b1, 2'h2, 32'h0102, 3'h1);
      chk({laneSeen, beats[3:0]}, 8'h12);
      for (k = 1; k < 4; k = k + 1) begin
         {area1_width_sel, area2_width_sel} = {k[1:0], k[1:0]};
         acc(32'h04000050, 1'b1, 2'h3, 32'h11223344, 3'h1 << (k - 1));
         chk(beats, 4 >> (k - 1));
         acc(32'h08000060, 1'b1, 2'h3, 32'h55667788, 3'h1 << (k - 1));
         chk(beats, 4 >> (k - 1));
      end
      {area1_width_sel, area2_width_sel, area2MemType} = 6'h11;
      acc(32'h08000070, 1'b1, 2'h3, 32'h12345678, 3'h2);
      chk(beats, 2);
      {area2MemType, dram_width_bit} = 3'h5;
      acc(32'h08000070, 1'b1, 2'h3, 32'h9abcdef0, 3'h4);
      chk(beats, 1);
      dram_width_bit = 1'b0;
      acc(32'h08000070, 1'b1, 2'h3, 32'h0badcafe, 3'h2);
      chk(beats, 2);
      lay(8'h70, 32'h0badcafe, 4);
      for (k = 0; k < 8; k = k + 1) begin
         {area0_wait_count, area12_wait_count} = {k[2:0], k[1:0]};
         acc(32'h00000011, 1'b0, 2'h1, 32'h0, 3'h1);
         chk(sCyc, 1 + w0(k[2:0]));
         acc(32'h04000012, 1'b0, 2'h1, 32'h0, 3'h1);
         chk(sCyc, 1 + k[1:0]);
      end
      {area0_wait_count, area12_wait_count, waitLen} = 9'h38;
      acc(32'h04000013, 1'b0, 2'h1, 32'h0, 3'h1);
      chk(sCyc, 11);
      {waitLen, area0BurstEnable} = 5'h01;
      acc(32'h00000080, 1'b1, 2'h3, 32'hfeedbeef, 3'h1);
      for (k = 0; k < 8; k = k + 7) begin
         area0_wait_count = k[2:0];
         acc(32'h00000080, 1'b0, 2'h3, 32'h0, 3'h1);
         chk({rdFalls[3:0], addrCh[3:0]}, 8'h13);
         chk(tL - tF, k == 0 ? 4 : 20);
         chk(rdOut, 32'hfeedbeef);
      end
      {area0BurstEnable, area0_wait_count} = 4'h0;
      rst(2'h2);
      acc(32'h00000090, 1'b1, 2'h3, 32'h31415926, 3'h2);
      chk({laneSeen, beats[3:0]}, 8'h32);
      print_verdict;
   end
endmodule
